// *** core/csfr_pkg.sv ***
// package for the core status flag register: bit layout, reset values,
// instruction classes and reset causes shared by the register and its users.
// assumes the execution unit classifies each instruction before it retires.
package csfr_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // bit positions of the status register
   localparam int unsigned PIN_WAKE_BIT   = 7;
   localparam int unsigned CMP_WAKE_BIT   = 6;
   localparam int unsigned RSVD_BIT       = 5;
   localparam int unsigned EXPIRY_BIT     = 4;
   localparam int unsigned SLEEP_BIT      = 3;
   localparam int unsigned ZERO_BIT       = 2;
   localparam int unsigned NIBBLE_BIT     = 1;
   localparam int unsigned CARRY_BIT      = 0;

   ////////////////////////////////////////////////////////////////////////////
   // masks and reset values
   localparam logic [7:0] WRITABLE_MASK   = 8'hE7;
   localparam logic [7:0] ARITH_MASK      = 8'h07;
   localparam logic [7:0] ZERO_ONLY_MASK  = 8'h04;
   localparam logic [7:0] CARRY_ONLY_MASK = 8'h01;
   localparam logic [7:0] NO_FLAG_MASK    = 8'h00;
   localparam logic [2:0] UPPER_POR       = 3'h0;
   localparam logic [1:0] EXPIRY_SLEEP_POR = 2'h3;
   // flag bits power up undefined; zero is an arbitrary defined choice
   localparam logic [2:0] ARITH_POR       = 3'h0;
   localparam logic [3:0] NIBBLE_MAX      = 4'hF;

   ////////////////////////////////////////////////////////////////////////////
   // instruction classes as seen by the status register
   typedef enum logic [3:0] {
      OP_NONE,
      OP_ADD,
      OP_SUB,
      OP_LOGIC,
      OP_ZERO_FILE,
      OP_ROT_RIGHT,
      OP_ROT_LEFT,
      OP_BIT_ZERO,
      OP_BIT_SET,
      OP_MOVE_WF,
      OP_PLAIN,
      OP_WDT_KICK,
      OP_SLEEP
   } csfr_op_e;

   typedef enum logic [1:0] {
      CAUSE_EXTERNAL,
      CAUSE_WDT,
      CAUSE_PIN_WAKE,
      CAUSE_CMP_WAKE
   } csfr_cause_e;

   typedef struct packed {
      logic        valid;
      csfr_op_e    op;
      logic        to_status;
      logic [7:0]  opnd_f;
      logic [7:0]  opnd_w;
      logic [7:0]  result;
   } csfr_exec_s;

   typedef struct packed {
      logic        valid;
      csfr_cause_e cause;
   } csfr_rst_s;

endpackage : csfr_pkg

// *** core/csfr_core.sv ***
// core status flag register: alu flags, watchdog and sleep state, wake causes.
// assumes one retiring instruction per clock on EXEC_I and one-cycle
// non-power-on reset events on RCAUSE_I; RST_I is the power-on reset.
//
// Behaviour
// - the register takes a destination write from any instruction like any data file register.
// - when the instruction updates zero, nibble carry or carry, its destination write to those bits is blocked.
// - instruction writes never change the watchdog expiry flag or the sleep entered flag.
// - a zero file instruction aimed here clears bits 7 to 5, sets zero and keeps the other bits.
// - single bit zero, single bit set and move working to file leave the three alu flags alone unless this register is their destination.
// - bit 7 is set by a reset from pin change wake and cleared by power-up or any other reset.
// - bit 6 is set by a reset from comparator wake on comparator variants and cleared by other resets.
// - bit 4 is set by power-up, the watchdog kick or sleep, and cleared by a watchdog time-out.
// - bit 3 is set by power-up or the watchdog kick instruction.
// - bit 3 is cleared whenever a sleep instruction executes.
// - bit 2 is set for a zero add, subtract, logic or zero file result and cleared for a nonzero one.
// - for add, bit 1 shows a carry out of the low nibble.
// - for subtract, bit 1 shows no borrow out of the low nibble.
// - bit 0 is the carry of add and the inverted borrow of subtract.
// - rotates load bit 0 with the operand lsb on right and msb on left.
`timescale 1ns/1ps

module csfr_core
   import csfr_pkg::*;
#(
   parameter bit HAS_COMPARATOR = 1'b1
) (
   input  wire logic       CLK_I,
   input  wire logic       RST_I,
   input  wire csfr_exec_s EXEC_I,
   input  wire csfr_rst_s  RCAUSE_I,
   output logic [7:0]      STATUS_O,
   output logic [7:0]      RESULT_O
);

   ////////////////////////////////////////////////////////////////////////////
   // elaboration check
   if (HAS_COMPARATOR !== 1'b0 && HAS_COMPARATOR !== 1'b1) begin : g_bad_param
      $error("HAS_COMPARATOR must be 0 or 1");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [7:0] status_ff;
   logic [7:0] nxt_status;
   logic [7:0] result_ff;
   logic [7:0] nxt_result;

   ////////////////////////////////////////////////////////////////////////////
   // decode
   wire logic       exec_go    = EXEC_I.valid & ~RCAUSE_I.valid;
   wire logic       is_add     = exec_go & (EXEC_I.op == OP_ADD);
   wire logic       is_sub     = exec_go & (EXEC_I.op == OP_SUB);
   wire logic       is_rot_r   = exec_go & (EXEC_I.op == OP_ROT_RIGHT);
   wire logic       is_rot_l   = exec_go & (EXEC_I.op == OP_ROT_LEFT);
   wire logic       is_kick    = exec_go & (EXEC_I.op == OP_WDT_KICK);
   wire logic       is_sleep   = exec_go & (EXEC_I.op == OP_SLEEP);
   wire logic       is_zfile   = exec_go & (EXEC_I.op == OP_ZERO_FILE);
   wire logic       is_logic   = exec_go & (EXEC_I.op == OP_LOGIC);
   wire logic       to_status  = exec_go & EXEC_I.to_status;
   wire logic       old_carry  = status_ff[CARRY_BIT];

   ////////////////////////////////////////////////////////////////////////////
   // arithmetic flag sources
   wire logic [8:0] add_full   = {1'b0, EXEC_I.opnd_f} + {1'b0, EXEC_I.opnd_w};
   wire logic [4:0] add_nib    = {1'b0, EXEC_I.opnd_f[3:0]} + {1'b0, EXEC_I.opnd_w[3:0]};
   wire logic [7:0] sub_res    = EXEC_I.opnd_f - EXEC_I.opnd_w;
   wire logic       sub_nob    = EXEC_I.opnd_f >= EXEC_I.opnd_w;
   wire logic       sub_nib_nob = EXEC_I.opnd_f[3:0] >= EXEC_I.opnd_w[3:0];
   wire logic [7:0] rot_r_res  = {old_carry, EXEC_I.opnd_f[7:1]};
   wire logic [7:0] rot_l_res  = {EXEC_I.opnd_f[6:0], old_carry};

   // destination value of the retiring instruction
   wire logic [7:0] alu_res    = is_add    ? add_full[7:0] :
                                 is_sub    ? sub_res :
                                 is_rot_r  ? rot_r_res :
                                 is_rot_l  ? rot_l_res :
                                 is_zfile  ? 8'h00 :
                                 EXEC_I.result;

   // flags the instruction itself drives
   wire logic [7:0] affect_mask = (is_add | is_sub)     ? ARITH_MASK :
                                  (is_logic | is_zfile) ? ZERO_ONLY_MASK :
                                  (is_rot_r | is_rot_l) ? CARRY_ONLY_MASK :
                                  NO_FLAG_MASK;

   // zero file keeps nibble carry and carry out of the destination write
   wire logic [7:0] block_mask  = affect_mask | (is_zfile ? ARITH_MASK : NO_FLAG_MASK);

   wire logic       new_zero   = (alu_res == 8'h00);
   wire logic       new_nibble = is_add ? (add_nib > {1'b0, NIBBLE_MAX}) : sub_nib_nob;
   wire logic       new_carry  = is_add   ? add_full[8] :
                                 is_sub   ? sub_nob :
                                 is_rot_r ? EXEC_I.opnd_f[0] :
                                 EXEC_I.opnd_f[7];

   // destination write reaches only writable bits not driven by flag logic
   wire logic [7:0] write_mask = to_status ? (WRITABLE_MASK & ~block_mask) : NO_FLAG_MASK;
   wire logic [7:0] written    = (status_ff & ~write_mask) | (alu_res & write_mask);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb begin
      nxt_status = written;
      if (affect_mask[ZERO_BIT]) begin
         nxt_status[ZERO_BIT] = new_zero;
      end
      if (affect_mask[NIBBLE_BIT]) begin
         nxt_status[NIBBLE_BIT] = new_nibble;
      end
      if (affect_mask[CARRY_BIT]) begin
         nxt_status[CARRY_BIT] = new_carry;
      end
      if (is_kick) begin
         nxt_status[EXPIRY_BIT] = 1'b1;
         nxt_status[SLEEP_BIT]  = 1'b1;
      end
      if (is_sleep) begin
         nxt_status[EXPIRY_BIT] = 1'b1;
         nxt_status[SLEEP_BIT]  = 1'b0;
      end
      if (RCAUSE_I.valid) begin
         nxt_status                = status_ff;
         nxt_status[PIN_WAKE_BIT]  = (RCAUSE_I.cause == CAUSE_PIN_WAKE);
         nxt_status[CMP_WAKE_BIT]  = HAS_COMPARATOR & (RCAUSE_I.cause == CAUSE_CMP_WAKE);
         if (RCAUSE_I.cause == CAUSE_WDT) begin
            nxt_status[EXPIRY_BIT] = 1'b0;
         end
      end
   end

   assign nxt_result = exec_go ? alu_res : result_ff;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         status_ff <= {UPPER_POR, EXPIRY_SLEEP_POR, ARITH_POR};
         result_ff <= 8'h00;
      end else begin
         status_ff <= nxt_status;
         result_ff <= nxt_result;
      end
   end

   assign STATUS_O = status_ff;
   assign RESULT_O = result_ff;

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (RST_I);

   wire logic       chk_add_z   = (add_full[7:0] == 8'h00);
   wire logic       chk_sub_z   = (sub_res == 8'h00);
   wire logic       chk_keep    = exec_go & ((EXEC_I.op == OP_BIT_ZERO) | (EXEC_I.op == OP_BIT_SET) |
                                             (EXEC_I.op == OP_MOVE_WF));
   wire logic       chk_ts_evt  = is_kick | is_sleep | RCAUSE_I.valid;
   logic            por_seen_ff;

   always_ff @(posedge CLK_I) begin
      if (RST_I) begin
         por_seen_ff <= 1'b1;
      end else begin
         por_seen_ff <= 1'b0;
      end
   end

   a_por_values: assert property (
      por_seen_ff |-> (STATUS_O[7:5] == UPPER_POR) && (STATUS_O[4:3] == EXPIRY_SLEEP_POR))
      else $error("power-on values of upper bits wrong");

   a_add_flags: assert property (
      is_add && !to_status |=> STATUS_O[CARRY_BIT] == $past(add_full[8]) &&
                               STATUS_O[NIBBLE_BIT] == $past(add_nib[4]) &&
                               STATUS_O[ZERO_BIT] == $past(chk_add_z))
      else $error("add flags wrong");

   a_sub_flags: assert property (
      is_sub |=> STATUS_O[CARRY_BIT] == $past(sub_nob) &&
                 STATUS_O[NIBBLE_BIT] == $past(sub_nib_nob) &&
                 STATUS_O[ZERO_BIT] == $past(chk_sub_z))
      else $error("subtract flags wrong");

   a_rotate_carry: assert property (
      (is_rot_r || is_rot_l) |=>
         STATUS_O[CARRY_BIT] == ($past(is_rot_r) ? $past(EXEC_I.opnd_f[0]) : $past(EXEC_I.opnd_f[7])))
      else $error("rotate carry load wrong");

   a_zero_file: assert property (
      is_zfile && to_status |=> STATUS_O[7:5] == 3'h0 && STATUS_O[ZERO_BIT] &&
                                STATUS_O[4:3] == $past(status_ff[4:3]) &&
                                STATUS_O[1:0] == $past(status_ff[1:0]))
      else $error("zero file on status wrong");

   a_flags_kept: assert property (
      chk_keep && !to_status |=> $stable(STATUS_O[2:0]))
      else $error("bit or move instruction touched alu flags");

   a_status_write: assert property (
      chk_keep && to_status |=> (STATUS_O & WRITABLE_MASK) == ($past(EXEC_I.result) & WRITABLE_MASK))
      else $error("status destination write lost");

   a_arith_block: assert property (
      is_add && to_status |=> STATUS_O[2:0] == {$past(chk_add_z), $past(add_nib[4]), $past(add_full[8])} &&
                              STATUS_O[7:5] == $past(add_full[7:5]))
      else $error("destination write reached alu flags");

   a_ro_bits: assert property (
      !chk_ts_evt |=> $stable(STATUS_O[4:3]))
      else $error("expiry or sleep bit changed by write");

   a_sleep_op: assert property (
      is_sleep |=> STATUS_O[4:3] == 2'b10 ##1 ($past(chk_ts_evt) || STATUS_O[4:3] == 2'b10))
      else $error("sleep did not set expiry and clear sleep bit");

   a_kick_op: assert property (
      is_kick |=> STATUS_O[4:3] == 2'b11)
      else $error("watchdog kick did not set expiry and sleep bits");

   a_wdt_cause: assert property (
      RCAUSE_I.valid && RCAUSE_I.cause == CAUSE_WDT |=>
         !STATUS_O[EXPIRY_BIT] && STATUS_O[7:6] == 2'b00 && $stable(STATUS_O[SLEEP_BIT]))
      else $error("watchdog time-out reset values wrong");

   a_wake_cause: assert property (
      RCAUSE_I.valid |=> STATUS_O[PIN_WAKE_BIT] == ($past(RCAUSE_I.cause) == CAUSE_PIN_WAKE) &&
                         STATUS_O[CMP_WAKE_BIT] == (HAS_COMPARATOR && $past(RCAUSE_I.cause) == CAUSE_CMP_WAKE))
      else $error("wake cause flags wrong");

   ////////////////////////////////////////////////////////////////////////////
   // result, hold and reset event checks

   a_logic_zero: assert property (
      is_logic |=> STATUS_O[ZERO_BIT] == ($past(EXEC_I.result) == 8'h00))
      else $error("logic zero flag wrong");

   a_logic_keep: assert property (
      is_logic && !to_status |=> $stable(STATUS_O[7:3]) && $stable(STATUS_O[1:0]))
      else $error("logic op touched other status bits");

   a_logic_write: assert property (
      is_logic && to_status |=> STATUS_O[7:5] == $past(EXEC_I.result[7:5]) &&
                                STATUS_O[1:0] == $past(EXEC_I.result[1:0]))
      else $error("logic write to status wrong");

   a_zfile_other: assert property (
      is_zfile && !to_status |=> STATUS_O[ZERO_BIT] && $stable(STATUS_O[7:3]) && $stable(STATUS_O[1:0]))
      else $error("zero file elsewhere changed status wrongly");

   a_zfile_result: assert property (
      is_zfile |=> RESULT_O == 8'h00)
      else $error("zero file result not zero");

   a_plain_keep: assert property (
      exec_go && EXEC_I.op == OP_PLAIN && !to_status |=> $stable(STATUS_O))
      else $error("plain op changed status");

   a_keep_result: assert property (
      chk_keep |=> RESULT_O == $past(EXEC_I.result))
      else $error("bit or move result wrong");

   a_add_result: assert property (
      is_add |=> RESULT_O == $past(EXEC_I.opnd_f) + $past(EXEC_I.opnd_w))
      else $error("add result wrong");

   a_sub_result: assert property (
      is_sub |=> RESULT_O == $past(EXEC_I.opnd_f) - $past(EXEC_I.opnd_w))
      else $error("subtract result wrong");

   a_rot_r_result: assert property (
      is_rot_r |=> RESULT_O == {$past(STATUS_O[CARRY_BIT]), $past(EXEC_I.opnd_f[7:1])})
      else $error("rotate right result wrong");

   a_rot_l_result: assert property (
      is_rot_l |=> RESULT_O == {$past(EXEC_I.opnd_f[6:0]), $past(STATUS_O[CARRY_BIT])})
      else $error("rotate left result wrong");

   a_kick_others: assert property (
      is_kick && !to_status |=> $stable(STATUS_O[7:5]) && $stable(STATUS_O[2:0]))
      else $error("watchdog kick touched other bits");

   a_sleep_others: assert property (
      is_sleep && !to_status |=> $stable(STATUS_O[7:5]) && $stable(STATUS_O[2:0]))
      else $error("sleep touched other bits");

   a_idle_hold: assert property (
      !exec_go && !RCAUSE_I.valid |=> $stable(STATUS_O) && $stable(RESULT_O))
      else $error("status or result moved while idle");

   a_cause_keep: assert property (
      RCAUSE_I.valid |=> $stable(RESULT_O) && $stable(STATUS_O[RSVD_BIT]) && $stable(STATUS_O[3:0]))
      else $error("reset event changed unrelated bits");

   a_cause_expiry: assert property (
      RCAUSE_I.valid && RCAUSE_I.cause != CAUSE_WDT |=> $stable(STATUS_O[EXPIRY_BIT]))
      else $error("non watchdog reset changed expiry flag");

   a_cmp_absent: assert property (
      !HAS_COMPARATOR && RCAUSE_I.valid |=> !STATUS_O[CMP_WAKE_BIT])
      else $error("comparator wake set without comparator");

   a_por_result: assert property (
      por_seen_ff |-> RESULT_O == 8'h00 && STATUS_O[2:0] == ARITH_POR)
      else $error("power-on result or flags wrong");

endmodule // csfr_core

// *** dv/csfr_exec_model.sv ***
// execution side model: hands retiring instructions and reset events to the status register.
// assumes the bench presents one request per clock, changed at the falling edge.
`timescale 1ns/1ps

module csfr_exec_model
   import csfr_pkg::*;
(
   input  wire csfr_exec_s req_i,
   input  wire csfr_rst_s  cause_i,
   output csfr_exec_s      exec_o,
   output csfr_rst_s       rcause_o
);
   // software stores zero into the reserved bit of the result field for status writes; add, subtract and rotate results still reach that bit unmasked
   always_comb begin
      exec_o = req_i;
      if (req_i.to_status) begin
         exec_o.result[RSVD_BIT] = 1'b0;
      end
   end
   assign rcause_o = cause_i;
endmodule // csfr_exec_model

// *** dv/core_status_flag_register_tb.sv ***
// self-checking bench for the status register: corner cases then seeded random traffic.
// assumes csfr_core and csfr_exec_model; inputs change at the falling clock edge.
`timescale 1ns/1ps
`define CHK(got, exp, msg) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
   $display("ERROR %0t: %s got %h expected %h", $time, msg, got, exp); end end

module core_status_flag_register_tb;
   import csfr_pkg::*;
   logic        clk_i, rst_i, chk_r, exp_nc6;
   csfr_exec_s  req, exec_w;
   csfr_rst_s   cause_req, rcause_w, nc;
   logic [7:0]  status, result, exp_s, exp_r, status_nc;
   logic [31:0] rnd_state, r1, r2;
   csfr_op_e    op;
   int          fails, cmp_count;

   csfr_exec_model partner (.req_i(req), .cause_i(cause_req), .exec_o(exec_w), .rcause_o(rcause_w));
   csfr_core #(.HAS_COMPARATOR(1'b1)) dut (.CLK_I(clk_i), .RST_I(rst_i), .EXEC_I(exec_w),
      .RCAUSE_I(rcause_w), .STATUS_O(status), .RESULT_O(result));
   csfr_core #(.HAS_COMPARATOR(1'b0)) dut_nc (.CLK_I(clk_i), .RST_I(rst_i), .EXEC_I(exec_w),
      .RCAUSE_I(rcause_w), .STATUS_O(status_nc), .RESULT_O());

   initial clk_i = 1'b0;
   always #5 clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      rnd_state ^= rnd_state << 13;
      rnd_state ^= rnd_state >> 17;
      rnd_state ^= rnd_state << 5;
      return rnd_state;
   endfunction

   function automatic csfr_exec_s ex(csfr_op_e o, logic ts, logic [7:0] f, logic [7:0] w, logic [7:0] r);
      return '{1'b1, o, ts, f, w, r};
   endfunction

   // expected {result, status} after one retired instruction
   function automatic logic [15:0] model(logic [7:0] s, csfr_exec_s e);
      logic [7:0] r, m;
      logic [2:0] fl;
      r = e.result;
      fl = s[2:0];
      m = NO_FLAG_MASK;
      case (e.op)
         OP_ADD: begin
            r = e.opnd_f + e.opnd_w;
            fl = {r == 8'h00, ({1'b0, e.opnd_f[3:0]} + e.opnd_w[3:0]) > 5'h0F,
                  ({1'b0, e.opnd_f} + e.opnd_w) > 9'h0FF};
            m = ARITH_MASK;
         end
         OP_SUB: begin
            r = e.opnd_f - e.opnd_w;
            fl = {r == 8'h00, e.opnd_f[3:0] >= e.opnd_w[3:0], e.opnd_f >= e.opnd_w};
            m = ARITH_MASK;
         end
         OP_LOGIC: begin
            fl[2] = (r == 8'h00);
            m = ZERO_ONLY_MASK;
         end
         OP_ZERO_FILE: begin
            r = 8'h00;
            fl[2] = 1'b1;
            m = ARITH_MASK;
         end
         OP_ROT_RIGHT: begin
            r = {s[0], e.opnd_f[7:1]};
            fl[0] = e.opnd_f[0];
            m = CARRY_ONLY_MASK;
         end
         OP_ROT_LEFT: begin
            r = {e.opnd_f[6:0], s[0]};
            fl[0] = e.opnd_f[7];
            m = CARRY_ONLY_MASK;
         end
         OP_WDT_KICK: s[4:3] = 2'h3;
         OP_SLEEP: s[4:3] = 2'h2;
         default: ;
      endcase
      if (e.to_status) s = (s & ~(WRITABLE_MASK & ~m)) | (r & WRITABLE_MASK & ~m);
      s[2:0] = (s[2:0] & ~m[2:0]) | (fl & m[2:0]);
      return {r, s};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   task automatic step(input csfr_exec_s e, input csfr_rst_s c);
      @(negedge clk_i);
      `CHK(status, exp_s, "status")
      if (chk_r) `CHK(result, exp_r, "result")
      `CHK(status_nc, ({exp_s[7], exp_nc6, exp_s[5:0]}), "status without comparator")
      req = e;
      cause_req = c;
      #1;
      if (rcause_w.valid) begin
         exp_s[7] = (rcause_w.cause == CAUSE_PIN_WAKE);
         exp_s[6] = (rcause_w.cause == CAUSE_CMP_WAKE);
         if (rcause_w.cause == CAUSE_WDT) exp_s[4] = 1'b0;
         exp_nc6 = 1'b0;
         chk_r = 1'b0;
      end else if (exec_w.valid) begin
         {exp_r, exp_s} = model(exp_s, exec_w);
         if (exec_w.to_status) exp_nc6 = exp_s[6];
         chk_r = (exec_w.op != OP_WDT_KICK) && (exec_w.op != OP_SLEEP);
      end
   endtask

   task automatic do_reset(input int n);
      @(negedge clk_i);
      rst_i = 1'b1;
      req = '0;
      cause_req = '0;
      repeat (n) @(negedge clk_i);
      rst_i = 1'b0;
      exp_s = 8'h18;
      exp_nc6 = 1'b0;
      exp_r = 8'h00;
      chk_r = 1'b1;
   endtask

   task automatic finish_test();
      $display("fails=%0d cmp_count=%0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rst_i = 1'b1;
      req = '0;
      cause_req = '0;
      nc = '0;
      fails = 0;
      cmp_count = 0;
      rnd_state = 32'h0B76FF86;
      do_reset(5);
      step(ex(OP_ADD, 1'b0, 8'h0F, 8'h01, 8'h00), nc);
      step(ex(OP_ADD, 1'b0, 8'hFF, 8'h01, 8'h00), nc);
      step(ex(OP_SUB, 1'b0, 8'h10, 8'h01, 8'h00), nc);
      step(ex(OP_SUB, 1'b0, 8'h05, 8'h05, 8'h00), nc);
      step(ex(OP_ROT_RIGHT, 1'b1, 8'h01, 8'h00, 8'h00), nc);
      step(ex(OP_ROT_LEFT, 1'b0, 8'h80, 8'h00, 8'h00), nc);
      step(ex(OP_BIT_SET, 1'b1, 8'h00, 8'h00, 8'hFF), nc);
      step(ex(OP_ZERO_FILE, 1'b1, 8'h00, 8'h00, 8'hFF), nc);
      step(ex(OP_LOGIC, 1'b1, 8'h00, 8'h00, 8'hC3), nc);
      step(ex(OP_SLEEP, 1'b0, 8'h00, 8'h00, 8'h00), nc);
      step(ex(OP_MOVE_WF, 1'b1, 8'h00, 8'h00, 8'h00), nc);
      step(ex(OP_WDT_KICK, 1'b0, 8'h00, 8'h00, 8'h00), nc);
      for (int i = 0; i < 4; i++) begin
         step(ex(OP_MOVE_WF, 1'b1, 8'h00, 8'h00, 8'hFF), '{1'b1, csfr_cause_e'(i)});
      end
      for (int k = 0; k < 400; k++) begin
         if (k == 200) do_reset(2);
         r1 = xs();
         r2 = xs();
         op = csfr_op_e'(4'(8'h01 + r1[7:0] % 8'h0C));
         step(ex(op, r1[8] && op != OP_WDT_KICK && op != OP_SLEEP, r2[7:0], r2[15:8], r2[23:16]),
              '{r1[11:9] == 3'h0, csfr_cause_e'(r1[13:12])});
      end
      step('0, nc);
      finish_test();
   end

   initial begin
      #50000;
      fails++;
      finish_test();
   end
endmodule // core_status_flag_register_tb
